/* alarm_pkg.sv */
// Package with constants and types for the alarm source aggregator
//
// Contract
// - Three sources: supply one lost, supply two lost, station link lost.
// - An auto-reset source is active only while its fault is present.
// - A manual source latches its fault and holds until acknowledged.
// - Every source has its own enable, set independently by software.
// - Every source has its own mode bit: set for auto, clear for manual.
// - Contact closes when booting, out of order or any source is active.
// - Contact opens only when operational and no source is active.
// - An acknowledge for a source clears that source's pending state only if its fault is already gone; an acknowledge during the fault is ignored.
// - Every source's pending status is readable, with a per-source clear.
// - Loss of one supply only raises its own source, if enabled.
package alarm_pkg;
   localparam int unsigned NUM_SRC = 3;
   localparam int unsigned SRC_PWR1 = 0;
   localparam int unsigned SRC_PWR2 = 1;
   localparam int unsigned SRC_LINK = 2;

   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 32;

   // Register byte addresses
   localparam logic [3:0] REG_ENABLE = 4'h0;
   localparam logic [3:0] REG_AUTO = 4'h4;
   localparam logic [3:0] REG_PENDING = 4'h8;
   localparam logic [3:0] REG_ACK = 4'hc;

   localparam logic [2:0] ENABLE_RST = 3'h0;
   localparam logic [2:0] AUTO_RST = 3'h0;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef enum logic [1:0] {
      PROD_BOOT = 2'h0,
      PROD_RUN = 2'h1,
      PROD_FAULT = 2'h2
   } prod_state_t;
endpackage : alarm_pkg

/* sync2.sv */
// Two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module sync2 #(
   parameter int unsigned W = 1
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : sync2

/* alarm_source.sv */
// One alarm source with enable, reset mode and acknowledge
`timescale 1ns/1ps
module alarm_source (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic fault,
   input wire logic enable,
   input wire logic auto_mode,
   input wire logic ack,
   output logic active
);
   logic latch_r;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         latch_r <= 1'b0;
      end else if (!enable) begin
         latch_r <= 1'b0;
      end else if (auto_mode) begin
         // Auto mode keeps no memory, so a later switch to manual is clean
         latch_r <= 1'b0;
      end else if (fault) begin
         // Fault beats a same-cycle ack
         latch_r <= 1'b1;
      end else if (ack) begin
         latch_r <= 1'b0;
      end
   end

   // Auto mode follows the fault; manual mode shows the latch or the present fault
   always_comb begin
      if (!enable) begin
         active = 1'b0;
      end else if (auto_mode) begin
         active = fault;
      end else begin
         active = latch_r | fault;
      end
   end
endmodule : alarm_source

/* alarm_source_aggregator.sv */
// Alarm aggregator top: register port, sources and contact drive
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
module alarm_source_aggregator (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic pwr1_lost,
   input wire logic pwr2_lost,
   input wire logic link_lost,
   input wire logic boot_done,
   input wire logic out_of_order,
   input wire logic [alarm_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [alarm_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [alarm_pkg::DATA_W-1:0] reg_rdata,
   output logic contact_closed,
   output logic [alarm_pkg::NUM_SRC-1:0] alarm_active
);
   localparam int unsigned N = alarm_pkg::NUM_SRC;

   alarm_pkg::reg_req_t req;
   logic [N-1:0] fault_raw;
   logic [N-1:0] fault_s;
   logic [1:0] prod_s;
   logic [N-1:0] enable_r;
   logic [N-1:0] auto_r;
   logic [N-1:0] ack_pulse;
   logic [N-1:0] active;
   logic [alarm_pkg::DATA_W-1:0] rdata_nxt;
   alarm_pkg::prod_state_t prod_r;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr,
                  rd: reg_rd};

   // Supply and link faults are pins; each feeds only its own source
   always_comb begin
      fault_raw = '0;
      fault_raw[alarm_pkg::SRC_PWR1] = pwr1_lost;
      fault_raw[alarm_pkg::SRC_PWR2] = pwr2_lost;
      fault_raw[alarm_pkg::SRC_LINK] = link_lost;
   end

   sync2 #(.W(N)) u_fault_sync (
      .core_clk(core_clk),
      .rst(rst),
      .d(fault_raw),
      .q(fault_s)
   );

   sync2 #(.W(2)) u_prod_sync (
      .core_clk(core_clk),
      .rst(rst),
      .d({out_of_order, boot_done}),
      .q(prod_s)
   );

   // Product condition; supplies play no part in it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prod_r <= alarm_pkg::PROD_BOOT;
      end else if (prod_s[1]) begin
         prod_r <= alarm_pkg::PROD_FAULT;
      end else if (prod_s[0]) begin
         prod_r <= alarm_pkg::PROD_RUN;
      end else begin
         prod_r <= alarm_pkg::PROD_BOOT;
      end
   end

   // Configuration registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         enable_r <= alarm_pkg::ENABLE_RST;
      end else if (req.wr && req.addr == alarm_pkg::REG_ENABLE) begin
         enable_r <= req.wdata[N-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         auto_r <= alarm_pkg::AUTO_RST;
      end else if (req.wr && req.addr == alarm_pkg::REG_AUTO) begin
         auto_r <= req.wdata[N-1:0];
      end
   end

   // Write-one-to-acknowledge, one pulse per written bit
   always_comb begin
      ack_pulse = '0;
      if (req.wr && req.addr == alarm_pkg::REG_ACK) begin
         ack_pulse = req.wdata[N-1:0];
      end
   end

   for (genvar i = 0; i < N; i++) begin : g_src
      alarm_source u_src (
         .core_clk(core_clk),
         .rst(rst),
         .fault(fault_s[i]),
         .enable(enable_r[i]),
         .auto_mode(auto_r[i]),
         .ack(ack_pulse[i]),
         .active(active[i])
      );
   end

   // Read mux; unmapped and write-only addresses read zero
   always_comb begin
      rdata_nxt = '0;
      unique case (req.addr)
         alarm_pkg::REG_ENABLE: rdata_nxt[N-1:0] = enable_r;
         alarm_pkg::REG_AUTO: rdata_nxt[N-1:0] = auto_r;
         alarm_pkg::REG_PENDING: rdata_nxt[N-1:0] = active;
         default: rdata_nxt = '0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (req.rd) begin
         reg_rdata <= rdata_nxt;
      end else begin
         reg_rdata <= '0;
      end
   end

   // Registered contact; closed is the safe state from reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         contact_closed <= 1'b1;
         alarm_active <= '0;
      end else begin
         alarm_active <= active;
         contact_closed <= (prod_r != alarm_pkg::PROD_RUN)
                           || (|active);
      end
   end
endmodule : alarm_source_aggregator

/* alarm_source_aggregator_monitor.sv */
// Port checker for the alarm aggregator
`timescale 1ns/1ps
module alarm_checker (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic pwr1_lost,
   input wire logic pwr2_lost,
   input wire logic link_lost,
   input wire logic boot_done,
   input wire logic out_of_order,
   input wire logic [alarm_pkg::ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [alarm_pkg::DATA_W-1:0] reg_rdata,
   input wire logic contact_closed,
   input wire logic [alarm_pkg::NUM_SRC-1:0] alarm_active
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_open_no_alarm: assert property (
      !contact_closed |-> !alarm_active) else $error("open with alarm");
   a_open_when_run: assert property (
      !contact_closed |-> $past(boot_done, 4) && !$past(out_of_order, 4))
      else $error("open");
   a_fault_closes: assert property (
      $past(out_of_order, 4) |-> contact_closed) else $error("not closed");
   a_rise_pwr1: assert property (
      $rose(alarm_active[0]) |-> $past(pwr1_lost, 3))
      else $error("bad rise 0");
   a_rise_pwr2: assert property (
      $rose(alarm_active[1]) |-> $past(pwr2_lost, 3))
      else $error("bad rise 1");
   a_rise_link: assert property (
      $rose(alarm_active[2]) |-> $past(link_lost, 3))
      else $error("bad rise 2");
   a_fall_link: assert property (
      $fell(alarm_active[2]) |-> !$past(link_lost, 3) || $past(reg_wr)
      || $past(reg_wr, 2)) else $error("bad fall 2");
   a_rdata_idle: assert property (
      reg_rdata != 0 |-> $past(reg_rd)) else $error("stray data");
   cover property ($fell(alarm_active[2]));
   cover property ($rose(contact_closed));
   cover property ($fell(contact_closed));
endmodule : alarm_checker
bind alarm_source_aggregator alarm_checker alarm_checker_i (.core_clk, .rst,
   .pwr1_lost, .pwr2_lost, .link_lost, .boot_done, .out_of_order, .reg_addr,
   .reg_wr, .reg_rd, .reg_rdata, .contact_closed, .alarm_active);

/* alarm_contact_reader.sv */
// Monitoring device polling the dry contact
`timescale 1ns/1ps
module alarm_contact_reader (
   input wire logic core_clk,
   input wire logic contact_closed,
   output logic alarm_seen
);
   // Polled once a clock, so it lags by one cycle
   always_ff @(posedge core_clk) begin
      alarm_seen <= contact_closed;
   end
endmodule : alarm_contact_reader

/* alarm_source_aggregator_tb_top.sv */
// Bench for the alarm aggregator
`timescale 1ns/1ps
module alarm_source_aggregator_tb_top;
   logic core_clk, rst, pwr1_lost, pwr2_lost, link_lost, boot_done;
   logic out_of_order, reg_wr, reg_rd, contact_closed, seen;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [2:0] alarm_active;
   int fails = 0;
   int compares = 0;
   alarm_source_aggregator alarm_source_aggregator_i (.core_clk, .rst,
      .pwr1_lost, .pwr2_lost, .link_lost, .boot_done, .out_of_order,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .contact_closed,
      .alarm_active);
   alarm_contact_reader alarm_contact_reader_i (.core_clk, .contact_closed,
      .alarm_seen(seen));
   always #20 core_clk = ~core_clk;
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         fails++;
         $display("wrong value at %0t: %h %h", $time, s, e);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : wt
   task automatic wr(input logic [3:0] a, input logic [2:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= {29'h0, d};
      reg_wr <= 1'b1;
      @(posedge core_clk) reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk) reg_rd <= 1'b0;
      wt(0);
      chk(reg_rdata, e);
   endtask : rd
   task automatic t_boot;
      rd(4'h0, 32'h0);
      rd(4'h4, 32'h0);
      rd(4'h8, 32'h0);
      chk(contact_closed, 32'h1);
      @(posedge core_clk) boot_done <= 1'b1;
      wt(7);
      chk(seen, 32'h0);
   endtask : t_boot
   task automatic t_auto;
      wr(4'h0, 3'h7);
      wr(4'h4, 3'h7);
      rd(4'h4, 32'h7);
      @(posedge core_clk) pwr2_lost <= 1'b1;
      wt(6);
      chk(alarm_active, 32'h2);
      chk(seen, 32'h1);
      rd(4'h8, 32'h2);
      @(posedge core_clk) pwr2_lost <= 1'b0;
      wt(6);
      chk(alarm_active, 32'h0);
      chk(seen, 32'h0);
   endtask : t_auto
   task automatic t_manual;
      wr(4'h4, 3'h0);
      @(posedge core_clk) link_lost <= 1'b1;
      wt(5);
      wr(4'hc, 3'h4);
      wt(3);
      chk(alarm_active, 32'h4);
      @(posedge core_clk) link_lost <= 1'b0;
      wt(5);
      chk(alarm_active, 32'h4);
      wr(4'hc, 3'h4);
      wt(3);
      chk(alarm_active, 32'h0);
   endtask : t_manual
   task automatic t_disable;
      @(posedge core_clk) pwr1_lost <= 1'b1;
      wt(5);
      chk(alarm_active, 32'h1);
      @(posedge core_clk) pwr1_lost <= 1'b0;
      wr(4'h0, 3'h6);
      wt(3);
      chk(alarm_active, 32'h0);
      wr(4'h0, 3'h7);
      wt(3);
      chk(alarm_active, 32'h0);
      wr(4'h0, 3'h6);
      rd(4'h0, 32'h6);
      @(posedge core_clk) pwr1_lost <= 1'b1;
      wt(5);
      rd(4'h8, 32'h0);
      @(posedge core_clk) out_of_order <= 1'b1;
      wt(6);
      chk(contact_closed, 32'h1);
   endtask : t_disable
   task automatic complete_run;
      if (fails == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   initial begin
      {core_clk, pwr1_lost, pwr2_lost, link_lost, boot_done} = 5'h0;
      {out_of_order, reg_wr, reg_rd, reg_addr, reg_wdata} = 39'h0;
      rst = 1'b1;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      t_boot;
      t_auto;
      t_manual;
      t_disable;
      complete_run;
   end
endmodule : alarm_source_aggregator_tb_top
